// ---- hw/tpd_defines.svh ----
// timing counts, codes and reset values for the tone pair decoder
`ifndef TPD_DEFINES_SVH
`define TPD_DEFINES_SVH

// clock rate and figures in their own units
`define TPD_CLK_HZ 25000000
`define TPD_PRESENT_DETECT_US 5000
`define TPD_ABSENT_DETECT_US 500
`define TPD_GUARD_PRESENT_US 30000
`define TPD_GUARD_ABSENT_US 30000
`define TPD_CODE_SETUP_NS 3400

// derived cycle counts; only the code setup time rounds up, the others are whole multiples
`define TPD_PRESENT_DETECT_CYC \
    ((`TPD_PRESENT_DETECT_US * (`TPD_CLK_HZ / 1000000)))
`define TPD_ABSENT_DETECT_CYC \
    ((`TPD_ABSENT_DETECT_US * (`TPD_CLK_HZ / 1000000)))
`define TPD_GUARD_PRESENT_CYC \
    ((`TPD_GUARD_PRESENT_US * (`TPD_CLK_HZ / 1000000)))
`define TPD_GUARD_ABSENT_CYC \
    ((`TPD_GUARD_ABSENT_US * (`TPD_CLK_HZ / 1000000)))
`define TPD_CODE_SETUP_CYC \
    ((`TPD_CODE_SETUP_NS * (`TPD_CLK_HZ / 1000000) + 999) / 1000)

// tone measurement: period counted in clk cycles between two rising edges
`define TPD_MEAS_WINDOW 32'd25000
// acceptance tolerance in tenths of a percent (1.5 %) plus 2 Hz
`define TPD_ACC_PERMIL 15
`define TPD_ACC_HZ 2

// nominal low group and high group frequencies in Hz
`define TPD_LOW0 697
`define TPD_LOW1 770
`define TPD_LOW2 852
`define TPD_LOW3 941
`define TPD_HIGH0 1209
`define TPD_HIGH1 1336
`define TPD_HIGH2 1477
`define TPD_HIGH3 1633

// register widths and reset values
`define TPD_CODE_W 4
`define TPD_CODE_RST 4'h0
`define TPD_CNT_W 24

// register map offsets (byte addresses)
`define TPD_REG_CTRL 4'h0
`define TPD_REG_STATUS 4'h4
`define TPD_REG_GTP 4'h8
`define TPD_REG_GTA 4'hc
`define TPD_CTRL_INH_BIT 0
`define TPD_CTRL_PD_BIT 1
`define TPD_UNMAPPED 32'hdead_0000

`endif

// ---- hw/tpd_pkg.sv ----
// types shared by the tone pair decoder files
package tpd_pkg;
    // gray coded steering states along the usual path
    typedef enum logic [1:0] {
        tpd_idle = 2'b00,
        tpd_qual = 2'b01,
        tpd_held = 2'b11,
        tpd_rels = 2'b10
    } tpd_state_t;
    typedef logic [1:0] tpd_idx_t;
endpackage

// ---- hw/tpd_tone_meter.sv ----
// one band's tone frequency meter with nominal table match
`timescale 1ns/1ps
`include "tpd_defines.svh"
module tpd_tone_meter import tpd_pkg::*; #(
    parameter bit high_group = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tone_in,
    output logic valid,
    output tpd_idx_t index
);
    // ==========================================================
    // period between rising edges, counted in clk cycles
    // ==========================================================
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic [15:0] run_cnt;
    logic [15:0] period;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else if (ce) begin
            s1 <= tone_in;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign rise = s2 & ~s3;
    always_ff @(posedge clk) begin
        if (rst) begin
            run_cnt <= 16'h0;
            period <= 16'h0;
        end else if (ce) begin
            if (rise) begin
                period <= run_cnt;
                run_cnt <= 16'h1;
            end else if (run_cnt != 16'hffff) begin
                // saturate so a silent line never wraps into a valid period
                run_cnt <= run_cnt + 16'h1;
            end
        end
    end
    // ==========================================================
    // nominal match, 1.5 % plus 2 Hz, narrower than 3.5 % reject
    // ==========================================================
    function automatic int nominal(input int i);
        int f;
        f = 0;
        case (i)
            0: f = high_group ? `TPD_HIGH0 : `TPD_LOW0;
            1: f = high_group ? `TPD_HIGH1 : `TPD_LOW1;
            2: f = high_group ? `TPD_HIGH2 : `TPD_LOW2;
            default: f = high_group ? `TPD_HIGH3 : `TPD_LOW3;
        endcase
        return f;
    endfunction
    logic [3:0] hit;
    // the last full period and the one still running are both judged,
    // so a tone that stops loses its match within about one period
    for (genvar g = 0; g < 4; g++) begin : g_match
        localparam int nom = nominal(g);
        localparam int tol = nom * `TPD_ACC_PERMIL / 1000 + `TPD_ACC_HZ;
        localparam int p_min = (`TPD_CLK_HZ + nom + tol - 1) / (nom + tol);
        localparam int p_max = `TPD_CLK_HZ / (nom - tol);
        assign hit[g] = (period >= 16'(p_min)) && (period <= 16'(p_max))
            && (run_cnt <= 16'(p_max));
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            valid <= 1'b0;
            index <= 2'b00;
        end else if (ce) begin
            valid <= |hit;
            index <= hit[3] ? 2'd3 : hit[2] ? 2'd2 : hit[1] ? 2'd1 : 2'd0;
        end
    end
endmodule // tpd_tone_meter

// ---- hw/tpd_decoder.sv ----
// tone pair decoder with steering, output latch and avalon registers
`timescale 1ns/1ps
`include "tpd_defines.svh"
module tpd_decoder import tpd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic low_tone_in,
    input wire logic high_tone_in,
    input wire logic code_output_enable,
    input wire logic extra_key_inhibit,
    input wire logic power_down_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic early_detect_flag,
    output logic guard_time_drive,
    output logic delayed_steer_valid,
    output logic [3:0] digit_code_out,
    output logic [3:0] digit_code_oe
);
    // ==========================================================
    // pin synchronisers
    // ==========================================================
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
        end else if (ce) begin
            pin_s1 <= {code_output_enable, extra_key_inhibit, power_down_in};
            pin_s2 <= pin_s1;
        end
    end
    logic toe_q;
    logic inh_pin;
    logic pd_pin;
    assign toe_q = pin_s2[2];
    assign inh_pin = pin_s2[1];
    assign pd_pin = pin_s2[0];

    // ==========================================================
    // registers
    // ==========================================================
    logic ctrl_inh;
    logic ctrl_pd;
    logic [`TPD_CNT_W-1:0] gtp_cyc;
    logic [`TPD_CNT_W-1:0] gta_cyc;
    logic inhibit;
    logic halted;
    assign inhibit = inh_pin | ctrl_inh;
    assign halted = pd_pin | ctrl_pd;
    logic run;
    assign run = ce & ~halted;

    // readdata is a flop, so a read costs one wait state: the word is
    // loaded at the first edge and offered with waitrequest low at the next
    logic rd_ack;
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ack <= 1'b0;
        end else if (ce) begin
            rd_ack <= avs_read & ~rd_ack;
        end
    end
    assign avs_waitrequest = avs_read & ~rd_ack;
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_inh <= 1'b0;
            ctrl_pd <= 1'b0;
            gtp_cyc <= `TPD_CNT_W'(`TPD_GUARD_PRESENT_CYC);
            gta_cyc <= `TPD_CNT_W'(`TPD_GUARD_ABSENT_CYC);
        end else if (ce && avs_write) begin
            unique case (avs_address)
                `TPD_REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        ctrl_inh <= avs_writedata[`TPD_CTRL_INH_BIT];
                        ctrl_pd <= avs_writedata[`TPD_CTRL_PD_BIT];
                    end
                end
                `TPD_REG_GTP: gtp_cyc <= avs_writedata[`TPD_CNT_W-1:0];
                `TPD_REG_GTA: gta_cyc <= avs_writedata[`TPD_CNT_W-1:0];
                default: ;
            endcase
        end
    end
    logic [1:0] st_code;
    logic [3:0] code_latch;
    tpd_state_t state;
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (ce && avs_read && !rd_ack) begin
            unique case (avs_address)
                `TPD_REG_CTRL: avs_readdata <= {30'h0, ctrl_pd, ctrl_inh};
                `TPD_REG_STATUS: avs_readdata <= {22'h0, state, code_latch,
                    delayed_steer_valid, guard_time_drive, early_detect_flag,
                    halted};
                `TPD_REG_GTP: avs_readdata <= {8'h0, gtp_cyc};
                `TPD_REG_GTA: avs_readdata <= {8'h0, gta_cyc};
                default: avs_readdata <= `TPD_UNMAPPED;
            endcase
        end
    end

    // ==========================================================
    // frequency measurement
    // ==========================================================
    logic low_ok;
    logic high_ok;
    tpd_idx_t low_idx;
    tpd_idx_t high_idx;
    tpd_tone_meter #(.high_group(1'b0)) u_low (
        .clk(clk),
        .rst(rst),
        .ce(run),
        .tone_in(low_tone_in),
        .valid(low_ok),
        .index(low_idx)
    );
    tpd_tone_meter #(.high_group(1'b1)) u_high (
        .clk(clk),
        .rst(rst),
        .ce(run),
        .tone_in(high_tone_in),
        .valid(high_ok),
        .index(high_idx)
    );
    logic pair_raw;
    // column four is the highest high group tone
    assign pair_raw = low_ok & high_ok & ~(inhibit & high_idx == 2'd3);
    logic [3:0] pair_code;
    // keypad table: 1..9 as is, 0 is ten, star eleven, hash twelve, A-D 13-0
    always_comb begin
        pair_code = 4'h0;
        if (high_idx == 2'd3) begin
            pair_code = 4'(4'hd + {2'b00, low_idx});
        end else if (low_idx == 2'd3) begin
            unique case (high_idx)
                2'd0: pair_code = 4'hb;
                2'd1: pair_code = 4'ha;
                default: pair_code = 4'hc;
            endcase
        end else begin
            pair_code = 4'(low_idx * 2'd3 + high_idx + 4'h1);
        end
    end

    // ==========================================================
    // early detect: signal condition qualified for the detect times
    // ==========================================================
    logic [`TPD_CNT_W-1:0] det_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            det_cnt <= '0;
            early_detect_flag <= 1'b0;
        end else if (run) begin
            if (pair_raw == early_detect_flag) begin
                det_cnt <= '0;
            end else if (!early_detect_flag &&
                         det_cnt >= `TPD_CNT_W'(`TPD_PRESENT_DETECT_CYC)) begin
                early_detect_flag <= 1'b1;
                det_cnt <= '0;
            end else if (early_detect_flag &&
                         det_cnt >= `TPD_CNT_W'(`TPD_ABSENT_DETECT_CYC)) begin
                early_detect_flag <= 1'b0;
                det_cnt <= '0;
            end else begin
                det_cnt <= det_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // steering: guard timers replace the external rc network
    // ==========================================================
    logic [`TPD_CNT_W-1:0] guard_cnt;
    logic [7:0] setup_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= tpd_idle;
            guard_cnt <= '0;
            code_latch <= `TPD_CODE_RST;
            st_code <= 2'b00;
            guard_time_drive <= 1'b0;
        end else if (run) begin
            unique case (state)
                tpd_idle: begin
                    guard_cnt <= '0;
                    if (early_detect_flag) begin
                        state <= tpd_qual;
                    end
                end
                tpd_qual: begin
                    if (!early_detect_flag) begin
                        state <= tpd_idle;
                    end else if (guard_cnt >= gtp_cyc) begin
                        code_latch <= pair_code;
                        guard_time_drive <= 1'b1;
                        state <= tpd_held;
                    end else begin
                        guard_cnt <= guard_cnt + 1'b1;
                    end
                end
                tpd_held: begin
                    guard_cnt <= '0;
                    if (!early_detect_flag) begin
                        guard_time_drive <= 1'b0;
                        state <= tpd_rels;
                    end
                end
                tpd_rels: begin
                    if (early_detect_flag) begin
                        guard_cnt <= '0;
                        state <= tpd_held;
                        guard_time_drive <= 1'b1;
                    end else if (guard_cnt >= gta_cyc) begin
                        state <= tpd_idle;
                    end else begin
                        guard_cnt <= guard_cnt + 1'b1;
                    end
                end
            endcase
        end
    end
    // delayed steer follows latch after the setup gap
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_cnt <= 8'h0;
            delayed_steer_valid <= 1'b0;
        end else if (run) begin
            if (state == tpd_held || state == tpd_rels) begin
                if (setup_cnt >= 8'(`TPD_CODE_SETUP_CYC)) begin
                    delayed_steer_valid <= 1'b1;
                end else begin
                    setup_cnt <= setup_cnt + 8'h1;
                end
            end else begin
                setup_cnt <= 8'h0;
                delayed_steer_valid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // three-state code bus
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            digit_code_out <= `TPD_CODE_RST;
        end else if (ce) begin
            digit_code_out <= code_latch;
        end
    end
    assign digit_code_oe = {4{toe_q}};
endmodule // tpd_decoder

// ---- test/tpd_decoder_sva.sv ----
// assertion checker for the tone pair decoder ports
`timescale 1ns/1ps
module tpd_decoder_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic code_output_enable,
    input wire logic power_down_in,
    input wire logic early_detect_flag,
    input wire logic guard_time_drive,
    input wire logic delayed_steer_valid,
    input wire logic [3:0] digit_code_out,
    input wire logic [3:0] digit_code_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // output bus
    oe_on_a: assert property (code_output_enable [*3] |->
        digit_code_oe == 4'hf) else $error("code bus not driven");
    oe_off_a: assert property (!code_output_enable [*3] |->
        digit_code_oe == 4'h0) else $error("code bus not released");
    // ==========================================================
    // steering
    guard_cause_a: assert property ($rose(guard_time_drive) |->
        $past(early_detect_flag)) else $error("guard without early");
    guard_hold_a: assert property (guard_time_drive &&
        early_detect_flag |=> guard_time_drive || !early_detect_flag)
        else $error("guard dropped early");
    valid_delay_a: assert property ($rose(guard_time_drive) |->
        ##[1:400] delayed_steer_valid) else $error("delayed steer late");
    code_setup_a: assert property ($rose(delayed_steer_valid) |->
        digit_code_out == $past(digit_code_out, 85))
        else $error("code not settled before delayed steer");
    code_quiet_a: assert property ($changed(digit_code_out) |->
        guard_time_drive) else $error("code changed without registration");
    pause_end_a: assert property ($fell(delayed_steer_valid) |->
        !early_detect_flag) else $error("pause ended with tones present");
    halt_a: assert property (power_down_in [*4] |->
        $stable(early_detect_flag) && $stable(delayed_steer_valid))
        else $error("decoding moved in power down");
    dig_c: cover property ($rose(delayed_steer_valid));
    grd_c: cover property ($rose(guard_time_drive));
    end_c: cover property ($fell(delayed_steer_valid));
endmodule // tpd_decoder_chk

bind tpd_decoder tpd_decoder_chk chk_i (
    .clk(clk),
    .rst(rst),
    .code_output_enable(code_output_enable),
    .power_down_in(power_down_in),
    .early_detect_flag(early_detect_flag),
    .guard_time_drive(guard_time_drive),
    .delayed_steer_valid(delayed_steer_valid),
    .digit_code_out(digit_code_out),
    .digit_code_oe(digit_code_oe)
);

// ---- test/tpd_host_model.sv ----
// host model that reads the latched digit through the output enable
`timescale 1ns/1ps
module tpd_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic delayed_steer_valid,
    input wire logic [3:0] digit_code_out,
    input wire logic [3:0] digit_code_oe,
    output logic code_output_enable,
    output logic [3:0] got_code,
    output logic got_valid
);
    logic [3:0] bus_seen;
    logic [3:0] last;
    // a floating line shows the inverse of its last level, never a hold
    always_comb bus_seen = (digit_code_oe & digit_code_out)
        | (~digit_code_oe & ~last);
    always_ff @(posedge clk) begin
        if (rst) begin
            code_output_enable <= 1'b0;
            got_valid <= 1'b0;
            got_code <= 4'h0;
            last <= 4'h0;
        end else begin
            last <= bus_seen;
            if (code_output_enable && digit_code_oe == 4'hf) begin
                got_code <= bus_seen;
                got_valid <= 1'b1;
                code_output_enable <= 1'b0;
            end else begin
                if (!delayed_steer_valid) begin
                    got_valid <= 1'b0;
                end
                if (!hold && delayed_steer_valid && !got_valid) begin
                    code_output_enable <= 1'b1;
                end
            end
        end
    end
endmodule // tpd_host_model

// ---- test/tone_pair_decoder_steering_test.sv ----
// testbench for the tone pair decoder
`timescale 1ns/1ps
`include "tpd_defines.svh"
module tone_pair_decoder_steering_test;
    logic clk, rst, low_tone_in, high_tone_in, code_output_enable;
    logic power_down_in, avs_read, avs_write, avs_waitrequest;
    logic early_detect_flag, guard_time_drive, delayed_steer_valid;
    logic hold, got_valid, tones_on, extra_key_inhibit;
    logic [3:0] avs_address, digit_code_out, digit_code_oe, got_code;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int errors = 0, n_checks = 0, cyc = 0, lo_half, hi_half;
    int lo_cnt, hi_cnt;

    tpd_decoder uut (.clk(clk), .rst(rst), .ce(1'b1),
        .low_tone_in(low_tone_in), .high_tone_in(high_tone_in),
        .code_output_enable(code_output_enable),
        .extra_key_inhibit(extra_key_inhibit),
        .power_down_in(power_down_in), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .early_detect_flag(early_detect_flag),
        .guard_time_drive(guard_time_drive),
        .delayed_steer_valid(delayed_steer_valid),
        .digit_code_out(digit_code_out), .digit_code_oe(digit_code_oe));
    tpd_host_model host (.clk(clk), .rst(rst), .hold(hold),
        .delayed_steer_valid(delayed_steer_valid),
        .digit_code_out(digit_code_out), .digit_code_oe(digit_code_oe),
        .code_output_enable(code_output_enable), .got_code(got_code),
        .got_valid(got_valid));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // limited tone sources, square waves counted in clock cycles
    always @(posedge clk) begin
        if (!tones_on) begin
            low_tone_in <= 1'b0;
            high_tone_in <= 1'b0;
            lo_cnt <= 0;
            hi_cnt <= 0;
        end else begin
            lo_cnt <= (lo_cnt + 1 >= lo_half) ? 0 : lo_cnt + 1;
            hi_cnt <= (hi_cnt + 1 >= hi_half) ? 0 : hi_cnt + 1;
            if (lo_cnt + 1 >= lo_half) low_tone_in <= ~low_tone_in;
            if (hi_cnt + 1 >= hi_half) high_tone_in <= ~high_tone_in;
        end
    end
    // detection alone takes about 150k cycles a digit, hence the ceiling
    always @(posedge clk) begin
        cyc++;
        if (cyc == 600000) begin
            errors++;
            give_verdict();
        end
    end
    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // the read stands until waitrequest is seen low, data taken there
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic await(input int which, input logic lvl);
        logic v;
        for (int k = 0; k < 300000; k++) begin
            case (which)
                0: v = early_detect_flag;
                1: v = guard_time_drive;
                2: v = delayed_steer_valid;
                default: v = got_valid;
            endcase
            if (v === lvl)
                return;
            @(posedge clk);
        end
    endtask
    task automatic tone(input int f_lo, input int f_hi);
        lo_half = `TPD_CLK_HZ / (2 * f_lo);
        hi_half = `TPD_CLK_HZ / (2 * f_hi);
        tones_on <= 1'b1;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        bus_rd(`TPD_REG_GTP, rd);
        chk("gtp reset", `TPD_GUARD_PRESENT_CYC, rd);
        bus_rd(`TPD_REG_CTRL, rd);
        chk("ctrl reset", 32'h0, rd);
        bus_wr(`TPD_REG_GTP, 32'd200);
        bus_wr(`TPD_REG_GTA, 32'd200);
        bus_rd(`TPD_REG_GTP, rd);
        chk("gtp write", 32'd200, rd);
        bus_rd(4'h1, rd);
        chk("unmapped", `TPD_UNMAPPED, rd);
        power_down_in <= 1'b1;
        repeat (3) @(posedge clk);
        bus_rd(`TPD_REG_STATUS, rd);
        chk("halted", 1'b1, rd[0]);
        power_down_in <= 1'b0;
        $display("registers done");
    endtask
    task automatic t_digit();
        tone(770, 1633);
        await(2, 1'b1);
        repeat (4) @(posedge clk);
        chk("bus while disabled", 4'h0, digit_code_oe);
        chk("guard at digit", 1'b1, guard_time_drive);
        hold <= 1'b0;
        await(3, 1'b1);
        chk("code read late", 4'he, got_code);
        // column-four pair still sounding: inhibit alone must end it
        extra_key_inhibit <= 1'b1;
        await(0, 1'b0);
        @(posedge clk);
        chk("guard at end", 1'b0, guard_time_drive);
        tones_on <= 1'b0;
        await(2, 1'b0);
        bus_rd(`TPD_REG_STATUS, rd);
        chk("code after pause", 4'he, rd[7:4]);
        extra_key_inhibit <= 1'b0;
        $display("digit done");
    endtask
    task automatic t_burst();
        // guard longer than the rest of the burst plus the absent detect time
        bus_wr(`TPD_REG_GTP, 32'd100000);
        tone(852, 1477);
        await(0, 1'b1);
        repeat (2000) @(posedge clk);
        tones_on <= 1'b0;
        await(0, 1'b0);
        repeat (30000) @(posedge clk);
        chk("burst guard", 1'b0, guard_time_drive);
        chk("burst code", 4'he, digit_code_out);
        $display("burst done");
    endtask

    initial begin
        rst = 1'b1;
        hold = 1'b1;
        tones_on = 1'b0;
        power_down_in = 1'b0;
        extra_key_inhibit = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_digit();
        t_burst();
        give_verdict();
    end
endmodule // tone_pair_decoder_steering_test
